//--- core/vdo_field_ctr.sv
// Purpose: Line counter per field with vertical sync fallback
// Assumes: line_start is a one-cycle pulse
// Notes: Field flips on detected vsync or on line count overflow
`timescale 1ns/10ps
`default_nettype none
module vdo_field_ctr
    import vdo_pkg::*;
#(
    parameter int unsigned FIELD_LINES = VDO_FIELD_LINES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic line_start,
    input wire logic vs_det,
    output logic field_even,
    output logic vs_start,
    output logic [9:0] line_no
);
    typedef struct packed {
        logic [9:0] line_no;
        logic field_even;
        logic vs_start;
    } vdo_fc_st_t;
    vdo_fc_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.vs_start = 1'b0;
        if (vs_det) begin
            st_nxt.line_no = 10'h000;
            st_nxt.field_even = ~st_r.field_even;
            st_nxt.vs_start = 1'b1;
        end else if (line_start) begin
            if (st_r.line_no == 10'(FIELD_LINES - 1)) begin
                st_nxt.line_no = 10'h000;
                st_nxt.field_even = ~st_r.field_even;
                st_nxt.vs_start = 1'b1;
            end else begin
                st_nxt.line_no = st_r.line_no + 10'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign field_even = st_r.field_even;
    assign vs_start = st_r.vs_start;
    assign line_no = st_r.line_no;
endmodule
`default_nettype wire

//--- core/vdo_line_ctr.sv
// Purpose: Free-running line lock counter with resync on detected sync
// Assumes: Sync detect pulses synchronous to sys_clk
// Notes: Overflow gives line pulses when no video is present
`timescale 1ns/10ps
`default_nettype none
module vdo_line_ctr
    import vdo_pkg::*;
#(
    parameter int unsigned LINE_CYC = VDO_LINE_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hs_det,
    output logic [11:0] pos,
    output logic line_start
);
    typedef struct packed {
        logic [11:0] pos;
        logic line_start;
    } vdo_lc_st_t;
    vdo_lc_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.line_start = 1'b0;
        if (hs_det || st_r.pos == 12'(LINE_CYC - 1)) begin
            st_nxt.pos = 12'h000;
            st_nxt.line_start = 1'b1;
        end else begin
            st_nxt.pos = st_r.pos + 12'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pos = st_r.pos;
    assign line_start = st_r.line_start;
endmodule
`default_nettype wire

//--- core/vdo_out_port.sv
// Purpose: Digital 4:2:2 output port with sync, field and active flags
// Assumes: Decoded samples and sync detects arrive synchronous to sys_clk
// Notes: Timing outputs have enables, low meaning driven
//
// Contract
// - All pins sampled or driven on the single master clock.
// - Reset initialises every state machine and register to defaults.
// - Chroma port carries unsigned codes from zero to maximum.
// - Chroma alternates blue then red difference, blue first each line.
// - Luma port limited to codes sixteen through maximum.
// - Valid strobe marks cycles with valid luma and chroma.
// - After either reset timing outputs float until driven again.
// - Horizontal sync pulse follows detected input horizontal sync.
// - Without video, line counter overflow keeps horizontal sync running.
// - Horizontal sync start and end positions are programmable.
// - Vertical sync on detection, else on line counter overflow.
// - Field flag low for odd field, high for even.
// - Without vertical sync, field toggles after 337 lines.
// - Active flag high during active portion of a line.
// - Burst output mode holds the active flag asserted.
// - Active flag free running, changes only on the clock.
`timescale 1ns/10ps
`default_nettype none
module vdo_out_port
    import vdo_pkg::*;
#(
    parameter int unsigned LINE_CYC = VDO_LINE_CYC,
    parameter int unsigned FIELD_LINES = VDO_FIELD_LINES,
    parameter int unsigned VS_LINES = VDO_VS_LINES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic [7:0] luma_in,
    input wire logic [7:0] blue_diff_sample,
    input wire logic [7:0] red_diff_sample,
    input wire logic sample_in_valid,
    input wire logic hs_det,
    input wire logic vs_det,
    input wire logic [11:0] hs_start,
    input wire logic [11:0] hs_end,
    input wire logic [11:0] act_start,
    input wire logic [11:0] act_end,
    input wire logic burst_mode,
    output logic [7:0] luma_out_port,
    output logic [7:0] chroma_out_port,
    output logic sample_valid_strobe,
    output logic hsync_out,
    output logic vsync_out,
    output logic field_out,
    output logic active_out,
    output logic timing_oe_n
);
    typedef struct packed {
        vdo_pix_t pix;
        vdo_tim_t tim;
        logic oe_n;
        logic cb_next;
        logic [9:0] vs_left;
        vdo_state_t state;
    } vdo_top_st_t;
    vdo_top_st_t st_r, st_nxt;

    logic [11:0] pos;
    logic line_start;
    logic field_even;
    logic vs_start;
    logic [9:0] line_no;
    logic in_act;
    logic in_hs;
    logic any_rst;

    function automatic logic [7:0] vdo_clamp(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic vdo_in_win(input logic [11:0] p, input logic [11:0] s,
                                        input logic [11:0] e);
        // Window may wrap past line end
        if (s <= e) begin
            return (p >= s) && (p < e);
        end
        return (p >= s) || (p < e);
    endfunction

    assign any_rst = sys_rst | soft_rst;

    vdo_line_ctr #(
        .LINE_CYC(LINE_CYC)
    ) u_line (
        .sys_clk(sys_clk),
        .sys_rst(any_rst),
        .hs_det(hs_det),
        .pos(pos),
        .line_start(line_start)
    );

    vdo_field_ctr #(
        .FIELD_LINES(FIELD_LINES)
    ) u_field (
        .sys_clk(sys_clk),
        .sys_rst(any_rst),
        .line_start(line_start),
        .vs_det(vs_det),
        .field_even(field_even),
        .vs_start(vs_start),
        .line_no(line_no)
    );

    assign in_hs = vdo_in_win(pos, hs_start, hs_end);
    assign in_act = vdo_in_win(pos, act_start, act_end);

    always_comb begin
        st_nxt = st_r;
        st_nxt.pix.valid = 1'b0;
        st_nxt.oe_n = 1'b0;
        st_nxt.tim.hsync = in_hs;
        st_nxt.tim.field = field_even;
        if (vs_start) begin
            st_nxt.vs_left = 10'(VS_LINES);
        end else if (line_start && st_r.vs_left != 10'h000) begin
            st_nxt.vs_left = st_r.vs_left - 10'h001;
        end
        st_nxt.tim.vsync = (st_nxt.vs_left != 10'h000);
        if (line_start) begin
            st_nxt.cb_next = 1'b1;
        end
        case (st_r.state)
            VDO_ST_OFF: begin
                st_nxt.state = VDO_ST_BLANK;
            end
            VDO_ST_BLANK: begin
                if (in_act) begin
                    st_nxt.state = VDO_ST_ACTIVE;
                end
            end
            VDO_ST_ACTIVE: begin
                if (!in_act) begin
                    st_nxt.state = VDO_ST_BLANK;
                end
            end
            default: begin
                st_nxt.state = VDO_ST_OFF;
            end
        endcase
        st_nxt.tim.active = burst_mode || (st_nxt.state == VDO_ST_ACTIVE);
        if (sample_in_valid && (burst_mode || in_act) && !line_start) begin
            st_nxt.pix.luma = vdo_clamp(luma_in, VDO_Y_MIN, VDO_Y_MAX);
            st_nxt.pix.chroma = vdo_clamp(st_r.cb_next ? blue_diff_sample : red_diff_sample,
                                          VDO_C_MIN, VDO_C_MAX);
            st_nxt.cb_next = ~st_r.cb_next;
            st_nxt.pix.valid = 1'b1;
        end
        st_nxt.tim.valid = st_nxt.pix.valid;
    end

    always_ff @(posedge sys_clk) begin
        if (any_rst) begin
            st_r <= '0;
            st_r.pix.luma <= VDO_Y_RST;
            st_r.pix.chroma <= VDO_C_RST;
            st_r.oe_n <= 1'b1;
            st_r.cb_next <= 1'b1;
            st_r.state <= VDO_ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign luma_out_port = st_r.pix.luma;
    assign chroma_out_port = st_r.pix.chroma;
    assign sample_valid_strobe = st_r.pix.valid;
    assign hsync_out = st_r.tim.hsync;
    assign vsync_out = st_r.tim.vsync;
    assign field_out = st_r.tim.field;
    assign active_out = st_r.tim.active;
    assign timing_oe_n = st_r.oe_n;
endmodule
`default_nettype wire

//--- core/vdo_pkg.sv
// Purpose: Shared constants and carriers for the video decoder output port
// Assumes: Single 50 MHz clock, synchronous active-high reset
// Notes: Timing counts are defaults; tops may override
package vdo_pkg;
    localparam int unsigned VDO_CLK_HZ = 50000000;
    localparam int unsigned VDO_LINE_US = 64;
    localparam int unsigned VDO_LINE_CYC = (VDO_LINE_US * (VDO_CLK_HZ / 1000000));
    localparam int unsigned VDO_FIELD_LINES = 337;
    localparam int unsigned VDO_VS_LINES = 3;
    localparam logic [7:0] VDO_Y_MIN = 8'h10;
    localparam logic [7:0] VDO_Y_MAX = 8'hff;
    localparam logic [7:0] VDO_C_MIN = 8'h00;
    localparam logic [7:0] VDO_C_MAX = 8'hff;
    localparam logic [7:0] VDO_Y_RST = 8'h10;
    localparam logic [7:0] VDO_C_RST = 8'h80;
    localparam logic [11:0] VDO_HS_START_RST = 12'h000;
    localparam logic [11:0] VDO_HS_END_RST = 12'h0eb;
    localparam logic [11:0] VDO_ACT_START_RST = 12'h0fa;
    localparam logic [11:0] VDO_ACT_END_RST = 12'hc4e;

    typedef enum logic [1:0] {
        VDO_ST_OFF,
        VDO_ST_BLANK,
        VDO_ST_ACTIVE
    } vdo_state_t;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
        logic valid;
    } vdo_pix_t;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic field;
        logic active;
        logic valid;
    } vdo_tim_t;

    typedef struct packed {
        logic [11:0] hs_start;
        logic [11:0] hs_end;
        logic [11:0] act_start;
        logic [11:0] act_end;
        logic burst_mode;
    } vdo_cfg_t;
endpackage

//--- tb/vdo_capture_model.sv
// Purpose: Capture side stand-in
// Assumes: Samples latched on the rising edge
// Notes: Keeps every valid sample, never stalls
`timescale 1ns/10ps
`default_nettype none
module vdo_capture_model
    import vdo_pkg::*;
(
    input wire logic sys_clk,
    input wire vdo_pix_t pix,
    output var int captured
);
    vdo_pix_t store[$];
    always @(posedge sys_clk) begin
        if (pix.valid) begin
            store.push_back(pix);
        end
        captured <= store.size();
    end
endmodule
`default_nettype wire

//--- tb/vdo_out_port_tb_top.sv
// Purpose: Self-checking bench for vdo_out_port
// Assumes: Short line and field counts via parameters
// Notes: Stream outputs judged at the falling edge, where they are settled; directed checks 1 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
module vdo_out_port_tb_top;
    import vdo_pkg::*;
    localparam int LC = 64;
    localparam int FL = 5;
    logic sys_clk = 1'h0, sys_rst = 1'h1, soft_rst = 1'h0, sample_in_valid = 1'h0, f;
    logic hs_det = 1'h0, vs_det = 1'h0, burst_mode = 1'h0, chk = 1'h0, pv, pd, blue = 1'h1;
    logic prst = 1'h1, ia;
    logic [7:0] luma_in = 8'h00, blue_diff_sample = 8'h00, red_diff_sample = 8'h00, pl, pb, pr;
    logic [11:0] hs_start = 12'h000, hs_end = 12'h008, act_start = 12'h008, act_end = 12'h038;
    logic [7:0] luma_out_port, chroma_out_port;
    logic sample_valid_strobe, hsync_out, vsync_out, field_out, active_out, timing_oe_n;
    int fails = 0, check_count = 0, cyc = 0, exp_cnt = 0, captured, hi, per, n;
    int mp = 0, q;
    vdo_pix_t pix;
    assign pix = '{luma_out_port, chroma_out_port, sample_valid_strobe};
    vdo_out_port #(.LINE_CYC(LC), .FIELD_LINES(FL), .VS_LINES(3)) u_dut (.sys_clk, .sys_rst,
        .soft_rst, .luma_in, .blue_diff_sample, .red_diff_sample, .sample_in_valid, .hs_det,
        .vs_det, .hs_start, .hs_end, .act_start, .act_end, .burst_mode, .luma_out_port,
        .chroma_out_port, .sample_valid_strobe, .hsync_out, .vsync_out, .field_out,
        .active_out, .timing_oe_n);
    vdo_capture_model u_cap (.sys_clk, .pix, .captured);
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic end_sim;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            end_sim();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Timeout bounds these waits
    task automatic hs_meas;
        while (hsync_out) tick(1);
        while (!hsync_out) tick(1);
        hi = 0;
        while (hsync_out) begin
            hi++;
            tick(1);
        end
        per = hi;
        while (!hsync_out) begin
            per++;
            tick(1);
        end
    endtask
    // Inputs seen one negedge earlier fed the edge just past
    always @(negedge sys_clk) begin
        // Line position mirror, before and after the edge just past
        q = mp;
        if (prst || pd || mp == LC - 1) begin
            mp = 0;
        end else begin
            mp++;
        end
        ia = (q >= act_start) && (q < act_end);
        if (chk) begin
            cmp(16'(active_out), 16'(ia));
            cmp(16'(sample_valid_strobe), 16'(pv && ia));
            // Line restart puts blue first
            if (q == 0) blue = 1'h1;
            if (sample_valid_strobe) begin
                exp_cnt++;
                cmp(16'(luma_out_port), 16'((pl < VDO_Y_MIN) ? VDO_Y_MIN : pl));
                cmp(16'(chroma_out_port), 16'(blue ? pb : pr));
                blue = !blue;
            end
        end
        pd = hs_det;
        prst = sys_rst || soft_rst;
        pv = sample_in_valid;
        pl = luma_in;
        pb = blue_diff_sample;
        pr = red_diff_sample;
    end
    initial begin
        void'($urandom(99));
        tick(20);
        cmp(16'(luma_out_port), 16'(VDO_Y_RST));
        cmp(16'(timing_oe_n), 16'h0001);
        sys_rst = 1'h0;
        tick(3);
        cmp(16'(timing_oe_n), 16'h0000);
        cmp(16'(field_out), 16'h0000);
        chk = 1'h1;
        hs_det = 1'h1;
        tick(1);
        hs_det = 1'h0;
        repeat (6 * LC) begin
            sample_in_valid = 1'($urandom);
            luma_in = 8'($urandom);
            blue_diff_sample = 8'($urandom);
            red_diff_sample = 8'($urandom);
            tick(1);
        end
        sample_in_valid = 1'h0;
        $display("done: stream");
        hs_meas();
        cmp(16'(hi), 16'h0008);
        cmp(16'(per), 16'(LC));
        hs_start = 12'h00a;
        hs_end = 12'h014;
        hs_meas();
        cmp(16'(hi), 16'h000a);
        $display("done: hsync");
        f = field_out;
        while (field_out === f) tick(1);
        f = field_out;
        n = 0;
        while (field_out === f) begin
            n++;
            tick(1);
        end
        cmp(16'(n), 16'(FL * LC));
        f = field_out;
        vs_det = 1'h1;
        tick(1);
        vs_det = 1'h0;
        tick(3);
        cmp(16'(field_out !== f), 16'h0001);
        cmp(16'(vsync_out), 16'h0001);
        $display("done: field");
        chk = 1'h0;
        burst_mode = 1'h1;
        tick(2);
        repeat (2 * LC) begin
            cmp(16'(active_out), 16'h0001);
            tick(1);
        end
        burst_mode = 1'h0;
        $display("done: burst");
        soft_rst = 1'h1;
        tick(1);
        soft_rst = 1'h0;
        cmp(16'(timing_oe_n), 16'h0001);
        cmp(16'(chroma_out_port), 16'(VDO_C_RST));
        tick(3);
        cmp(16'(timing_oe_n), 16'h0000);
        cmp(16'(captured), 16'(exp_cnt));
        $display("done: soft reset");
        end_sim();
    end
endmodule
`default_nettype wire

//--- tb/vdo_port_monitor.sv
// Purpose: Port assertions for vdo_out_port
// Assumes: Bound to the top module, sys_rst synchronous
// Notes: Hsync restart check only fires for the 0..8 window
`timescale 1ns/10ps
`default_nettype none
module vdo_port_monitor
    import vdo_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic sample_in_valid,
    input wire logic hs_det,
    input wire logic [11:0] hs_start,
    input wire logic [11:0] hs_end,
    input wire logic burst_mode,
    input wire logic [7:0] luma_out_port,
    input wire logic sample_valid_strobe,
    input wire logic hsync_out,
    input wire logic vsync_out,
    input wire logic field_out,
    input wire logic active_out,
    input wire logic timing_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_hs_pulse;
        hsync_out [*7];
    endsequence
    sequence s_run;
        (!soft_rst && !sys_rst) [*3];
    endsequence
    a_luma_floor: assert property (sample_valid_strobe |-> luma_out_port >= VDO_Y_MIN)
        else $error("luma below floor");
    a_rst_float: assert property (disable iff (1'b0) sys_rst |=> timing_oe_n)
        else $error("timing outputs driven after reset");
    a_rst_defaults: assert property ($past(sys_rst) |-> luma_out_port == VDO_Y_RST)
        else $error("reset defaults wrong");
    a_valid_cause: assert property (sample_valid_strobe |-> $past(sample_in_valid))
        else $error("strobe without input sample");
    a_burst_active: assert property (burst_mode && !soft_rst && !timing_oe_n |=> active_out)
        else $error("active low in burst mode");
    a_hs_restart: assert property (hs_det && hs_start == 12'h000 && hs_end == 12'h008 && !soft_rst
        |-> ##[1:2] s_hs_pulse)
        else $error("hsync pulse missing after detect");
    a_vs_field: assert property ($changed(field_out) && !timing_oe_n |-> ##[0:2] vsync_out)
        else $error("field change without vsync");
    a_oe_driven: assert property (s_run |-> !timing_oe_n)
        else $error("timing outputs still floated");
endmodule
bind vdo_out_port vdo_port_monitor u_mon (.sys_clk, .sys_rst, .soft_rst, .sample_in_valid,
    .hs_det, .hs_start, .hs_end, .burst_mode, .luma_out_port, .sample_valid_strobe, .hsync_out,
    .vsync_out, .field_out, .active_out, .timing_oe_n);
`default_nettype wire
